// >>> logic/sjp_regs.vh
// Constants for the combined serial-wire / JTAG port front end
`ifndef SJP_REGS_VH
`define SJP_REGS_VH
// Pin indices on the five-pin debug group
`define SJP_PIN_MODE 0
`define SJP_PIN_CLK 1
`define SJP_PIN_TDI 2
`define SJP_PIN_TDO 3
`define SJP_PIN_RST 4
// Pin ownership settings
`define SJP_CFG_FULL 2'h0
`define SJP_CFG_NO_RST 2'h1
`define SJP_CFG_SW_ONLY 2'h2
`define SJP_CFG_RELEASED 2'h3
`define SJP_CFG_RESET 2'h0
// Pins owned per setting
`define SJP_MAP_FULL 5'h1f
`define SJP_MAP_NO_RST 5'h0f
`define SJP_MAP_SW_ONLY 5'h03
`define SJP_MAP_RELEASED 5'h00
// Debug pulls: up on reset, data in and mode; down on clock
`define SJP_DBG_PULL_UP 5'h15
`define SJP_DBG_PULL_DN 5'h02
// Switch sequence framing, in link clock cycles
`define SJP_HI_RUN 6'h32
`define SJP_PATTERN 16'h79e7
`define SJP_PAT_LEN 5'h10
`define SJP_IDLE_LOW 2'h2
// Instruction register widths and codes
`define SJP_BSC_IR_W 5
`define SJP_CORE_IR_W 4
`define SJP_CORE_IDCODE_INS 4'he
`endif

// >>> logic/sjp_swj_port.v
// Combined serial-wire / JTAG debug port front end with pin ownership
`timescale 1ns/10ps
`include "sjp_regs.vh"
module sjp_swj_port
#(
  parameter [`SJP_BSC_IR_W-1:0] BSC_IDCODE_INS = 5'h01,
  parameter [31:0] BSC_ID_VALUE = 32'h00000001, // Arbitrary value
  parameter [31:0] CORE_ID_VALUE = 32'h00000003 // Arbitrary value
)
(
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire i_sys_rst_n,
  input wire [4:0] i_pad_in,
  output reg [4:0] o_pad_out,
  output reg [4:0] o_pad_oe_n,
  output reg [4:0] o_pad_pu,
  output reg [4:0] o_pad_pd,
  input wire [4:0] i_gpio_out,
  input wire [4:0] i_gpio_oe_n,
  input wire [4:0] i_gpio_pu,
  input wire [4:0] i_gpio_pd,
  input wire i_pin_cfg_wr,
  input wire [1:0] i_pin_cfg,
  input wire i_trace_en_wr,
  input wire i_trace_en,
  input wire i_trace_swo,
  input wire i_swd_dout,
  input wire i_swd_doe,
  output reg o_swd_mode,
  output reg o_swd_clk_rise,
  output reg o_swd_din,
  output reg o_swd_line_reset,
  output reg o_swd_idle,
  output wire [`SJP_BSC_IR_W-1:0] o_bsc_ir,
  output wire [`SJP_CORE_IR_W-1:0] o_core_ir
);
  localparam [2:0] SW_OFF = 3'h1;
  localparam [2:0] SW_LRST = 3'h2;
  localparam [2:0] SW_IDLE = 3'h4;
  localparam [1:0] DT_HUNT = 2'h1;
  localparam [1:0] DT_SHIFT = 2'h2;

  function [4:0] owned_pins;
    input [1:0] cfg;
    begin
      case (cfg)
        `SJP_CFG_FULL: owned_pins = `SJP_MAP_FULL;
        `SJP_CFG_NO_RST: owned_pins = `SJP_MAP_NO_RST;
        `SJP_CFG_SW_ONLY: owned_pins = `SJP_MAP_SW_ONLY;
        default: owned_pins = `SJP_MAP_RELEASED;
      endcase
    end
  endfunction

  function [4:0] pick;
    input [4:0] own;
    input [4:0] dbg;
    input [4:0] gpio;
    begin
      pick = (dbg & own) | (gpio & ~own);
    end
  endfunction

  reg [4:0] pad_s1_q;
  reg [4:0] pad_s2_q;
  reg clk_prev_q;
  reg rst_s1_q;
  reg rst_s2_q;
  reg [1:0] cfg_q;
  reg trace_q;
  reg sw_sel_q;
  reg [5:0] hi_cnt_q;
  reg [1:0] lo_cnt_q;
  reg [1:0] det_q;
  reg [15:0] pat_q;
  reg [4:0] pat_cnt_q;
  reg [2:0] sw_st_q;
  wire [4:0] own;
  wire tck_rise;
  wire tck_fall;
  wire tms_s;
  wire hi_run;
  wire [15:0] pat_next;
  wire tap_tms;
  wire tap_trst;
  wire bsc_tdo;
  wire core_tdo;
  wire core_tdo_en;
  reg [4:0] dbg_out;
  reg [4:0] dbg_oe_n;

  assign own = owned_pins(cfg_q);
  // Clock pin edges seen only while the clock pin belongs to debug
  assign tck_rise = own[`SJP_PIN_CLK] & pad_s2_q[`SJP_PIN_CLK] & ~clk_prev_q;
  assign tck_fall = own[`SJP_PIN_CLK] & ~pad_s2_q[`SJP_PIN_CLK] & clk_prev_q;
  assign tms_s = pad_s2_q[`SJP_PIN_MODE];
  assign hi_run = (hi_cnt_q > `SJP_HI_RUN);
  assign pat_next = {pat_q[14:0], tms_s};
  assign tap_tms = sw_sel_q | tms_s;
  assign tap_trst = sw_sel_q | (own[`SJP_PIN_RST] & ~pad_s2_q[`SJP_PIN_RST]);

  // Pads and system reset come from outside this clock
  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pad_s1_q <= 5'h0;
      pad_s2_q <= 5'h0;
      clk_prev_q <= 1'b0;
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      pad_s1_q <= i_pad_in;
      pad_s2_q <= pad_s1_q;
      clk_prev_q <= pad_s2_q[`SJP_PIN_CLK];
      rst_s1_q <= i_sys_rst_n;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Ownership and trace assignment return to defaults on either reset
  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cfg_q <= `SJP_CFG_RESET;
      trace_q <= 1'b0;
    end
    else if (!rst_s2_q)
    begin
      cfg_q <= `SJP_CFG_RESET;
      trace_q <= 1'b0;
    end
    else
    begin
      if (i_pin_cfg_wr)
        cfg_q <= i_pin_cfg;
      if (i_trace_en_wr)
        trace_q <= i_trace_en;
    end
  end

  // Mode-line run counter, switch detector and serial line state.
  // System reset leaves the port selection alone so the switch can be
  // made while the core is held.
  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sw_sel_q <= 1'b0;
      hi_cnt_q <= 6'h0;
      lo_cnt_q <= 2'h0;
      det_q <= DT_HUNT;
      pat_q <= 16'h0;
      pat_cnt_q <= 5'h0;
      sw_st_q <= SW_OFF;
    end
    else if (tck_rise)
    begin
      if (!tms_s)
        hi_cnt_q <= 6'h0;
      else if (!hi_run)
        hi_cnt_q <= hi_cnt_q + 6'h1;
      if (tms_s)
        lo_cnt_q <= 2'h0;
      else if (lo_cnt_q != `SJP_IDLE_LOW)
        lo_cnt_q <= lo_cnt_q + 2'h1;
      if (!sw_sel_q)
      begin
        case (det_q)
          DT_HUNT:
          begin
            if (hi_run && !tms_s)
            begin
              det_q <= DT_SHIFT;
              pat_q <= pat_next;
              pat_cnt_q <= 5'h1;
            end
          end
          DT_SHIFT:
          begin
            pat_q <= pat_next;
            pat_cnt_q <= pat_cnt_q + 5'h1;
            if (pat_cnt_q == `SJP_PAT_LEN - 5'h1)
            begin
              det_q <= DT_HUNT;
              if (pat_next == `SJP_PATTERN)
              begin
                sw_sel_q <= 1'b1;
                sw_st_q <= SW_LRST;
              end
              // Mismatch waits for a fresh high run
            end
          end
          default: det_q <= DT_HUNT;
        endcase
      end
      else
      begin
        case (sw_st_q)
          SW_LRST:
            if (!tms_s && lo_cnt_q == `SJP_IDLE_LOW - 2'h1)
              sw_st_q <= SW_IDLE;
          SW_IDLE:
            if (tms_s && hi_cnt_q == `SJP_HI_RUN)
              sw_st_q <= SW_LRST;
          default: sw_st_q <= SW_LRST;
        endcase
      end
    end
  end

  // Boundary TAP first, core TAP last: 5+4 instruction bits
  sjp_tap
  #(
    .IR_W(`SJP_BSC_IR_W),
    .IDCODE_INS(BSC_IDCODE_INS),
    .ID_VALUE(BSC_ID_VALUE)
  )
  u_bsc_tap
  (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_trst(tap_trst),
    .i_rise(tck_rise),
    .i_fall(tck_fall),
    .i_tms(tap_tms),
    .i_tdi(pad_s2_q[`SJP_PIN_TDI]),
    .o_tdo(bsc_tdo),
    .o_tdo_en(),
    .o_ir(o_bsc_ir)
  );

  // Core is reached only through the boundary TAP's shift path
  sjp_tap
  #(
    .IR_W(`SJP_CORE_IR_W),
    .IDCODE_INS(`SJP_CORE_IDCODE_INS),
    .ID_VALUE(CORE_ID_VALUE)
  )
  u_core_tap
  (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_trst(tap_trst),
    .i_rise(tck_rise),
    .i_fall(tck_fall),
    .i_tms(tap_tms),
    .i_tdi(bsc_tdo),
    .o_tdo(core_tdo),
    .o_tdo_en(core_tdo_en),
    .o_ir(o_core_ir)
  );

  // Debug-side pad drive; only mode and data-out pins ever drive
  always @*
  begin
    dbg_out = 5'h0;
    dbg_oe_n = 5'h1f;
    if (sw_sel_q)
    begin
      dbg_out[`SJP_PIN_MODE] = i_swd_dout;
      dbg_oe_n[`SJP_PIN_MODE] = ~i_swd_doe;
      dbg_out[`SJP_PIN_TDO] = i_trace_swo;
      dbg_oe_n[`SJP_PIN_TDO] = ~trace_q;
    end
    else
    begin
      dbg_out[`SJP_PIN_TDO] = core_tdo;
      dbg_oe_n[`SJP_PIN_TDO] = ~core_tdo_en;
    end
  end

  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pad_out <= 5'h0;
      o_pad_oe_n <= 5'h1f;
      o_pad_pu <= `SJP_DBG_PULL_UP;
      o_pad_pd <= `SJP_DBG_PULL_DN;
      o_swd_mode <= 1'b0;
      o_swd_clk_rise <= 1'b0;
      o_swd_din <= 1'b1;
      o_swd_line_reset <= 1'b0;
      o_swd_idle <= 1'b0;
    end
    else
    begin
      o_pad_out <= pick(own, dbg_out, i_gpio_out);
      o_pad_oe_n <= pick(own, dbg_oe_n, i_gpio_oe_n);
      o_pad_pu <= pick(own, `SJP_DBG_PULL_UP, i_gpio_pu);
      o_pad_pd <= pick(own, `SJP_DBG_PULL_DN, i_gpio_pd);
      o_swd_mode <= sw_sel_q;
      o_swd_clk_rise <= tck_rise & sw_sel_q;
      o_swd_din <= tms_s;
      o_swd_line_reset <= (sw_st_q == SW_LRST);
      o_swd_idle <= (sw_st_q == SW_IDLE);
    end
  end
endmodule

// >>> logic/sjp_tap.v
// One test access port controller with bypass and identification registers
`timescale 1ns/10ps
module sjp_tap
#(
  parameter IR_W = 4,
  parameter [IR_W-1:0] IDCODE_INS = {IR_W{1'b0}},
  parameter [31:0] ID_VALUE = 32'h00000001
)
(
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire i_trst,
  input wire i_rise,
  input wire i_fall,
  input wire i_tms,
  input wire i_tdi,
  output reg o_tdo,
  output reg o_tdo_en,
  output reg [IR_W-1:0] o_ir
);
  localparam [15:0] ST_TLR = 16'h0001;
  localparam [15:0] ST_RTI = 16'h0002;
  localparam [15:0] ST_SDS = 16'h0004;
  localparam [15:0] ST_CDR = 16'h0008;
  localparam [15:0] ST_SHDR = 16'h0010;
  localparam [15:0] ST_E1DR = 16'h0020;
  localparam [15:0] ST_PDR = 16'h0040;
  localparam [15:0] ST_E2DR = 16'h0080;
  localparam [15:0] ST_UDR = 16'h0100;
  localparam [15:0] ST_SIS = 16'h0200;
  localparam [15:0] ST_CIR = 16'h0400;
  localparam [15:0] ST_SHIR = 16'h0800;
  localparam [15:0] ST_E1IR = 16'h1000;
  localparam [15:0] ST_PIR = 16'h2000;
  localparam [15:0] ST_E2IR = 16'h4000;
  localparam [15:0] ST_UIR = 16'h8000;

  reg [15:0] st_q;
  reg [15:0] st_d;
  reg [IR_W-1:0] irsh_q;
  reg [31:0] dr_q;
  wire is_id;

  assign is_id = (o_ir == IDCODE_INS);

  always @*
  begin
    case (st_q)
      ST_TLR: st_d = i_tms ? ST_TLR : ST_RTI;
      ST_RTI: st_d = i_tms ? ST_SDS : ST_RTI;
      ST_SDS: st_d = i_tms ? ST_SIS : ST_CDR;
      ST_CDR: st_d = i_tms ? ST_E1DR : ST_SHDR;
      ST_SHDR: st_d = i_tms ? ST_E1DR : ST_SHDR;
      ST_E1DR: st_d = i_tms ? ST_UDR : ST_PDR;
      ST_PDR: st_d = i_tms ? ST_E2DR : ST_PDR;
      ST_E2DR: st_d = i_tms ? ST_UDR : ST_SHDR;
      ST_UDR: st_d = i_tms ? ST_SDS : ST_RTI;
      ST_SIS: st_d = i_tms ? ST_TLR : ST_CIR;
      ST_CIR: st_d = i_tms ? ST_E1IR : ST_SHIR;
      ST_SHIR: st_d = i_tms ? ST_E1IR : ST_SHIR;
      ST_E1IR: st_d = i_tms ? ST_UIR : ST_PIR;
      ST_PIR: st_d = i_tms ? ST_E2IR : ST_PIR;
      ST_E2IR: st_d = i_tms ? ST_UIR : ST_SHIR;
      ST_UIR: st_d = i_tms ? ST_SDS : ST_RTI;
      default: st_d = ST_TLR;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q <= ST_TLR;
      irsh_q <= {IR_W{1'b0}};
      dr_q <= 32'h0;
      o_ir <= IDCODE_INS;
      o_tdo <= 1'b0;
      o_tdo_en <= 1'b0;
    end
    else if (i_trst)
    begin
      st_q <= ST_TLR;
      o_ir <= IDCODE_INS;
      o_tdo_en <= 1'b0;
    end
    else
    begin
      if (i_rise)
      begin
        st_q <= st_d;
        case (st_q)
          ST_TLR: o_ir <= IDCODE_INS;
          ST_CIR: irsh_q <= {{(IR_W-1){1'b0}}, 1'b1};
          ST_SHIR: irsh_q <= {i_tdi, irsh_q[IR_W-1:1]};
          ST_UIR: o_ir <= irsh_q;
          ST_CDR: dr_q <= is_id ? ID_VALUE : 32'h0;
          ST_SHDR:
          begin
            if (is_id)
              dr_q <= {i_tdi, dr_q[31:1]};
            else
              dr_q <= {31'h0, i_tdi}; // Bypass adds one bit
          end
          default: dr_q <= dr_q;
        endcase
      end
      if (i_fall)
      begin
        o_tdo <= (st_q == ST_SHIR) ? irsh_q[0] : dr_q[0];
        o_tdo_en <= (st_q == ST_SHIR) || (st_q == ST_SHDR);
      end
    end
  end
endmodule

// >>> verification/sjp_host_model.sv
// Debugger host model driving test clock, mode, data in and test reset
`timescale 1ns/10ps
module sjp_host_model
(
  input wire i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n
);
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_trst_n = 1'b1;
  end
  // Clock stands low between frames; data out read just before the fall,
  // since the port answers several reference cycles after our fall.
  // Pins move a few ns off the grid the callers start on, so no pin
  // change ever meets a sampling edge; one cycle still takes 200 ns.
  task cycle(input logic tms, input logic tdi, output logic tdo);
    #3 o_tms = tms;
    o_tdi = tdi;
    #95 o_tck = 1'b1;
    #100 tdo = i_tdo;
    o_tck = 1'b0;
    #2;
  endtask
  // Test reset pin held low for one clock period
  task trst_pulse;
    #3 o_trst_n = 1'b0;
    #195 o_trst_n = 1'b1;
    #2;
  endtask
  task run(input logic tms, input int n);
    logic d;
    for (int i = 0; i < n; i++)
      cycle(tms, 1'b1, d);
  endtask
  // From idle: shift n bits LSB first, then back to idle
  task scan(input logic ir, input int n, input logic [39:0] din,
    output logic [39:0] dout);
    logic d;
    cycle(1'b1, 1'b1, d);
    if (ir)
      cycle(1'b1, 1'b1, d);
    run(1'b0, 2);
    for (int i = 0; i < n; i++)
      cycle(i == n - 1, din[i], dout[i]);
    cycle(1'b1, 1'b1, d);
    cycle(1'b0, 1'b1, d);
  endtask
  task swj(input logic [15:0] pat);
    logic d;
    run(1'b1, 51);
    for (int i = 15; i >= 0; i--)
      cycle(pat[i], 1'b1, d);
    run(1'b1, 51);
  endtask
endmodule

// >>> verification/sjp_swj_port_properties.sv
// Assertions on the ports of the debug port front end
`timescale 1ns/10ps
module sjp_swj_port_properties
(
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire [4:0] o_pad_pu,
  input wire [4:0] o_pad_pd,
  input wire o_swd_mode,
  input wire o_swd_clk_rise,
  input wire o_swd_din,
  input wire o_swd_line_reset,
  input wire o_swd_idle,
  input wire [4:0] o_bsc_ir,
  input wire [3:0] o_core_ir
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_out_of_reset;
    $rose(i_arst_n);
  endsequence
  sequence s_switch;
    $rose(o_swd_mode);
  endsequence
  sequence s_relapse;
    o_swd_idle ##1 o_swd_line_reset;
  endsequence
  reset_state_a: assert property (
    s_out_of_reset |-> !o_swd_mode && o_pad_pu == 5'h15 &&
    o_pad_pd == 5'h02) else $error("bad state after reset");
  mode_sticky_a: assert property (
    o_swd_mode |=> o_swd_mode) else $error("serial mode dropped");
  switch_reset_a: assert property (
    s_switch |-> o_swd_line_reset && !o_swd_idle)
    else $error("switch without line reset");
  jtag_quiet_a: assert property (
    !o_swd_mode |-> !o_swd_line_reset && !o_swd_idle && !o_swd_clk_rise)
    else $error("serial activity in jtag mode");
  idle_entry_a: assert property (
    $rose(o_swd_idle) |-> !o_swd_din && $past(o_swd_line_reset))
    else $error("idle without low line");
  idle_excl_a: assert property (
    !(o_swd_idle && o_swd_line_reset)) else $error("idle and reset");
  rise_pulse_a: assert property (
    o_swd_clk_rise |=> !o_swd_clk_rise [*3])
    else $error("clock rise pulse too long");
  tap_parked_a: assert property (
    o_swd_mode |-> o_bsc_ir == 5'h01 && o_core_ir == 4'he)
    else $error("taps not held in reset");
  relapse_high_a: assert property (
    s_relapse |-> o_swd_din) else $error("line reset with low line");
endmodule
bind sjp_swj_port sjp_swj_port_properties u_props
(
  .i_ref_clk(i_ref_clk),
  .i_arst_n(i_arst_n),
  .o_pad_pu(o_pad_pu),
  .o_pad_pd(o_pad_pd),
  .o_swd_mode(o_swd_mode),
  .o_swd_clk_rise(o_swd_clk_rise),
  .o_swd_din(o_swd_din),
  .o_swd_line_reset(o_swd_line_reset),
  .o_swd_idle(o_swd_idle),
  .o_bsc_ir(o_bsc_ir),
  .o_core_ir(o_core_ir)
);

// >>> verification/sjp_swj_port_tb_top.sv
// Testbench for the combined debug port front end
`timescale 1ns/10ps
module sjp_swj_port_tb_top;
  localparam [31:0] CORE_ID = 32'h00000003; // Arbitrary value
  logic clk, rst_n, sys_n, cfg_wr, trc_wr, trc_en, swo, dout, doe;
  logic [1:0] cfg;
  logic [4:0] g_out, g_oe_n, g_pu, g_pd;
  logic [39:0] q;
  wire [4:0] p_out, p_oe_n, p_pu, p_pd, pad, bir;
  wire [3:0] cir;
  wire tck, tms, tdi, trst_n, mode, din, lr, idl;
  int fails, checked, cyc;
  // Undriven data out shows the inverse of its last value
  assign pad = {trst_n, p_oe_n[3] ? ~p_out[3] : p_out[3], tdi, tck, tms};
  sjp_swj_port #(.CORE_ID_VALUE(CORE_ID)) dut
  (
    .i_ref_clk(clk), .i_arst_n(rst_n), .i_sys_rst_n(sys_n),
    .i_pad_in(pad), .o_pad_out(p_out), .o_pad_oe_n(p_oe_n),
    .o_pad_pu(p_pu), .o_pad_pd(p_pd), .i_gpio_out(g_out),
    .i_gpio_oe_n(g_oe_n), .i_gpio_pu(g_pu), .i_gpio_pd(g_pd),
    .i_pin_cfg_wr(cfg_wr), .i_pin_cfg(cfg), .i_trace_en_wr(trc_wr),
    .i_trace_en(trc_en), .i_trace_swo(swo), .i_swd_dout(dout),
    .i_swd_doe(doe), .o_swd_mode(mode), .o_swd_clk_rise(),
    .o_swd_din(din), .o_swd_line_reset(lr), .o_swd_idle(idl),
    .o_bsc_ir(bir), .o_core_ir(cir)
  );
  sjp_host_model host
  (
    .i_tdo(pad[3]), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .o_trst_n(trst_n)
  );
  task chk(input string nm, input logic [39:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task set_trace(input logic en);
    @(posedge clk);
    trc_wr <= 1'b1;
    trc_en <= en;
    @(posedge clk);
    trc_wr <= 1'b0;
  endtask
  task test_reset;
    chk("mode", mode, 0);
    chk("pullup", p_pu, 5'h15);
    chk("pulldown", p_pd, 5'h02);
    chk("bsc_ir", bir, 5'h01);
    $display("test reset done");
  endtask
  task test_chain;
    set_trace(1'b1);
    // Taps leave reset in Test-Logic-Reset; step to idle first
    host.run(1'b0, 1);
    host.scan(1'b1, 9, {5'h1f, 4'ha}, q);
    chk("trace_jtag", p_oe_n[3], 1);
    chk("ir_capture", q[8:0], 9'h011);
    chk("bsc_ir", bir, 5'h1f);
    chk("core_ir", cir, 4'ha);
    host.scan(1'b1, 9, {5'h1f, 4'he}, q);
    host.scan(1'b0, 34, {40{1'b1}}, q);
    chk("dr_bypass", q[33:0], {2'b10, CORE_ID});
    host.trst_pulse;
    chk("bsc_trst", bir, 5'h01);
    $display("test chain done");
  endtask
  task test_pins;
    logic [4:0] maps [4];
    logic [4:0] m;
    maps = '{5'h1f, 5'h0f, 5'h03, 5'h00};
    for (int c = 0; c < 4; c++)
    begin
      m = maps[c];
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg <= c[1:0];
      @(posedge clk);
      cfg_wr <= 1'b0;
      repeat (6) @(posedge clk);
      chk("pu", p_pu, (m & 5'h15) | (~m & g_pu));
      chk("pd", p_pd, (m & 5'h02) | (~m & g_pd));
      chk("oe_n", p_oe_n, m);
      chk("out", p_out & ~m, g_out & ~m);
    end
    sys_n <= 1'b0;
    repeat (4) @(posedge clk);
    sys_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("pu_sysrst", p_pu, 5'h15);
    $display("test pins done");
  endtask
  task test_switch;
    sys_n <= 1'b0;
    host.swj(16'h79e6);
    chk("bad_pattern", mode, 0);
    host.swj(16'h79e7);
    chk("mode", mode, 1);
    chk("line_reset", lr, 1);
    chk("bsc_parked", bir, 5'h01);
    host.run(1'b0, 2);
    repeat (4) @(posedge clk);
    chk("idle", {idl, lr}, 2'b10);
    // Fifty highs are not yet more than fifty
    host.run(1'b1, 50);
    chk("no_relapse", {idl, lr}, 2'b10);
    host.run(1'b1, 1);
    chk("relapse", {idl, lr}, 2'b01);
    host.run(1'b0, 2);
    sys_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("trace_off", p_oe_n[3], 1);
    $display("test switch done");
  endtask
  task test_trace;
    set_trace(1'b1);
    swo <= 1'b1;
    repeat (8) @(posedge clk);
    chk("trace_hi", {p_oe_n[3], p_out[3]}, 2'b01);
    swo <= 1'b0;
    doe <= 1'b1;
    dout <= 1'b1;
    repeat (8) @(posedge clk);
    chk("trace_lo", {p_oe_n[3], p_out[3]}, 2'b00);
    chk("swd_data", {p_oe_n[0], p_out[0]}, 2'b01);
    doe <= 1'b0;
    dout <= 1'b0;
    $display("test trace done");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      complete_run;
    end
  end
  initial
  begin
    {rst_n, cfg_wr, trc_wr, trc_en, swo, dout, doe, cfg} = 0;
    sys_n = 1'b1;
    g_out = 5'h1b;
    g_oe_n = 5'h00;
    g_pu = 5'h0a;
    g_pd = 5'h05;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    test_reset;
    test_chain;
    test_pins;
    test_switch;
    test_trace;
    complete_run;
  end
endmodule
